// ===== logic/aord_top.sv
// module: overrange detector top, registers, comparators and pins
`default_nettype none
// Overview of operation
// R1: channel flag 0 when sample reaches threshold 0
// R2: channel flag 1 when sample reaches threshold 1
// R3: threshold means value over 256 of full scale
// R4: threshold 0 resets to 0xF2
// R5: threshold 1 resets to 0xAB
// R6: config bit 3 enables pins, else low
// R7: pulse lasts at least 8 times 2^exp
// R8: config register resets to 0x07
// R9: software should keep pulse exponent at maximum
// R10: each pin follows its flag, events restart
module aord_top
    import aord_pkg::*;
(
    // clock and reset
    input wire logic CLK_I,
    input wire logic RESETN_I,
    // converter samples, signed two's complement
    input wire logic [AORD_SAMPLE_W-1:0] CHAN_A_SAMPLE_I,
    input wire logic [AORD_SAMPLE_W-1:0] CHAN_B_SAMPLE_I,
    // register port
    input wire logic [9:0] REG_ADDR_I,
    input wire logic [7:0] REG_WDATA_I,
    input wire logic REG_WR_I,
    input wire logic REG_RD_I,
    output logic [7:0] REG_RDATA_O,
    // overrange pins
    output logic CHAN_A_PIN_0_O,
    output logic CHAN_A_PIN_1_O,
    output logic CHAN_B_PIN_0_O,
    output logic CHAN_B_PIN_1_O
);
    typedef struct packed {
        logic [7:0] level_threshold_0;
        logic [7:0] level_threshold_1;
        logic [7:0] overrange_config;
        logic [7:0] rdata;
        logic [3:0] event_hit;
    } aord_top_state_t;

    aord_top_state_t state_q;
    aord_top_state_t state_d;
    logic [1:0] rst_sync_q;
    logic rst_n;
    logic [AORD_SAMPLE_W-1:0] mag_a;
    logic [AORD_SAMPLE_W-1:0] mag_b;
    logic [2:0] wr_sel;
    logic [2:0] rd_sel;

    aord_flag_if flag_if ();

    // ------------------------------------------------------------
    // reset release
    // ------------------------------------------------------------
    always_ff @(posedge CLK_I or negedge RESETN_I) begin
        if (!RESETN_I) begin
            rst_sync_q <= 2'h0;
        end else begin
            rst_sync_q <= {rst_sync_q[0], 1'b1};
        end
    end
    assign rst_n = rst_sync_q[1];

    // ------------------------------------------------------------
    // magnitude and compare
    // ------------------------------------------------------------
    // most negative code saturates so it still reads as full scale
    function automatic logic [AORD_SAMPLE_W-1:0] abs_sample(
        input logic [AORD_SAMPLE_W-1:0] s
    );
        logic [AORD_SAMPLE_W-1:0] n;
        n = ~s + AORD_SAMPLE_W'(1);
        if (!s[AORD_SAMPLE_W-1]) begin
            return s;
        end else if (n[AORD_SAMPLE_W-1]) begin
            return {1'b0, {(AORD_SAMPLE_W-1){1'b1}}};
        end else begin
            return n;
        end
    endfunction

    // threshold/256 of full scale: compare against the 8 msbs of
    // the magnitude below the sign, low bits truncated
    function automatic logic reaches(
        input logic [AORD_SAMPLE_W-1:0] mag,
        input logic [7:0] thr
    );
        return mag[AORD_SAMPLE_W-2 -: 8] >= thr; // R3
    endfunction

    assign mag_a = abs_sample(CHAN_A_SAMPLE_I);
    assign mag_b = abs_sample(CHAN_B_SAMPLE_I);

    // ------------------------------------------------------------
    // threshold events
    // ------------------------------------------------------------
    // four raw events in pin order: a0, a1, b0, b1
    function automatic logic [3:0] sample_events(
        input logic [AORD_SAMPLE_W-1:0] mag_x,
        input logic [AORD_SAMPLE_W-1:0] mag_y,
        input logic [7:0] thr_0,
        input logic [7:0] thr_1
    );
        logic [3:0] hit;
        hit[0] = reaches(mag_x, thr_0); // R1
        hit[1] = reaches(mag_x, thr_1); // R2
        hit[2] = reaches(mag_y, thr_0); // R1
        hit[3] = reaches(mag_y, thr_1); // R2
        return hit;
    endfunction

    // ------------------------------------------------------------
    // register decode
    // ------------------------------------------------------------
    // one-hot select, shared by the write and the read path
    function automatic logic [2:0] reg_select(
        input logic [9:0] addr
    );
        logic [2:0] sel;
        sel = 3'h0;
        unique case (addr)
            AORD_ADDR_LEVEL_THRESHOLD_0: begin
                sel = 3'h1;
            end
            AORD_ADDR_LEVEL_THRESHOLD_1: begin
                sel = 3'h2;
            end
            AORD_ADDR_OVERRANGE_CONFIG: begin
                sel = 3'h4;
            end
            default: begin
                // unmapped: writes dropped, reads give zero
                sel = 3'h0;
            end
        endcase
        return sel;
    endfunction

    // ------------------------------------------------------------
    // read path
    // ------------------------------------------------------------
    // and-or mux; an empty select reads as zero
    function automatic logic [7:0] read_mux(
        input logic [2:0] sel,
        input logic [7:0] thr_0,
        input logic [7:0] thr_1,
        input logic [7:0] cfg
    );
        return ({8{sel[0]}} & thr_0)
               | ({8{sel[1]}} & thr_1)
               | ({8{sel[2]}} & cfg);
    endfunction

    assign wr_sel = REG_WR_I ? reg_select(REG_ADDR_I) : 3'h0;
    assign rd_sel = REG_RD_I ? reg_select(REG_ADDR_I) : 3'h0;

    // config fields, kept beside the register layout
    function automatic logic [2:0] cfg_exp(input logic [7:0] cfg);
        return cfg[AORD_CFG_EXP_MSB:AORD_CFG_EXP_LSB];
    endfunction

    function automatic logic cfg_enable(input logic [7:0] cfg);
        return cfg[AORD_CFG_ENABLE_BIT];
    endfunction

    // ------------------------------------------------------------
    // register file and flags
    // ------------------------------------------------------------
    always_comb begin
        state_d = state_q;
        state_d.event_hit = sample_events(mag_a, mag_b,
                                          state_q.level_threshold_0,
                                          state_q.level_threshold_1);
        // writes land next cycle; reserved config bits stay zero
        if (wr_sel[0]) begin
            state_d.level_threshold_0 = REG_WDATA_I;
        end
        if (wr_sel[1]) begin
            state_d.level_threshold_1 = REG_WDATA_I;
        end
        if (wr_sel[2]) begin
            state_d.overrange_config = REG_WDATA_I & AORD_CFG_WRITE_MASK;
        end
        // read data stand one cycle, zero otherwise
        state_d.rdata = read_mux(rd_sel, state_q.level_threshold_0,
                                 state_q.level_threshold_1,
                                 state_q.overrange_config);
    end

    always_ff @(posedge CLK_I or negedge rst_n) begin
        if (!rst_n) begin
            state_q.level_threshold_0 <= AORD_RST_THRESHOLD_0; // R4
            state_q.level_threshold_1 <= AORD_RST_THRESHOLD_1; // R5
            state_q.overrange_config <= AORD_RST_CONFIG; // R8
            state_q.rdata <= 8'h00;
            state_q.event_hit <= 4'h0;
        end else begin
            state_q <= state_d;
        end
    end

    // ------------------------------------------------------------
    // pulse stretch and pins
    // ------------------------------------------------------------
    assign flag_if.event_hit = state_q.event_hit;
    assign flag_if.pulse_length_exp =
        cfg_exp(state_q.overrange_config); // R7
    assign flag_if.flag_output_enable =
        cfg_enable(state_q.overrange_config); // R6

    aord_stretch u_stretch (
        .clk_i(CLK_I),
        .rst_n_i(rst_n),
        .flag_if(flag_if.stretch)
    );

    assign REG_RDATA_O = state_q.rdata;
    assign CHAN_A_PIN_0_O = flag_if.pin_level[0]; // R10
    assign CHAN_A_PIN_1_O = flag_if.pin_level[1]; // R10
    assign CHAN_B_PIN_0_O = flag_if.pin_level[2]; // R10
    assign CHAN_B_PIN_1_O = flag_if.pin_level[3]; // R10
endmodule // aord_top
`default_nettype wire

// ===== inc/aord_pkg.sv
// package: register map, field layout and timing of the overrange detector
`default_nettype none
package aord_pkg;
    // ------------------------------------------------------------
    // register offsets (10-bit address)
    // ------------------------------------------------------------
    localparam logic [9:0] AORD_ADDR_LEVEL_THRESHOLD_0 = 10'h211;
    localparam logic [9:0] AORD_ADDR_LEVEL_THRESHOLD_1 = 10'h212;
    localparam logic [9:0] AORD_ADDR_OVERRANGE_CONFIG = 10'h213;
    // ------------------------------------------------------------
    // reset values
    // ------------------------------------------------------------
    localparam logic [7:0] AORD_RST_THRESHOLD_0 = 8'hf2;
    localparam logic [7:0] AORD_RST_THRESHOLD_1 = 8'hab;
    localparam logic [7:0] AORD_RST_CONFIG = 8'h07;
    // ------------------------------------------------------------
    // config field layout
    // ------------------------------------------------------------
    localparam int AORD_CFG_ENABLE_BIT = 3;
    localparam int AORD_CFG_EXP_MSB = 2;
    localparam int AORD_CFG_EXP_LSB = 0;
    localparam logic [7:0] AORD_CFG_WRITE_MASK = 8'h0f;
    // ------------------------------------------------------------
    // sample and pulse timing
    // ------------------------------------------------------------
    localparam int AORD_SAMPLE_W = 12;
    localparam int AORD_PULSE_BASE_LOG2 = 3;  // base length 8 cycles
    localparam int AORD_CNT_W = 11;           // holds 8 * 2**7 = 1024
    localparam int AORD_NUM_FLAGS = 4;
endpackage : aord_pkg
`default_nettype wire

// ===== inc/aord_flag_if.sv
// interface: raw overrange events and pulse-stretch settings
`default_nettype none
interface aord_flag_if;
    logic [3:0] event_hit;
    logic [2:0] pulse_length_exp;
    logic flag_output_enable;
    logic [3:0] pin_level;
    modport src (
        output event_hit,
        output pulse_length_exp,
        output flag_output_enable,
        input pin_level
    );
    modport stretch (
        input event_hit,
        input pulse_length_exp,
        input flag_output_enable,
        output pin_level
    );
endinterface : aord_flag_if
`default_nettype wire

// ===== logic/aord_stretch.sv
// module: per-pin minimum-length pulse stretchers for overrange outputs
`default_nettype none
module aord_stretch
    import aord_pkg::*;
(
    // clock and reset
    input wire logic clk_i,
    input wire logic rst_n_i,
    // flag channel
    aord_flag_if.stretch flag_if
);
    typedef struct packed {
        logic [AORD_NUM_FLAGS-1:0][AORD_CNT_W-1:0] cnt;
        logic [AORD_NUM_FLAGS-1:0] pin;
    } aord_stretch_state_t;

    aord_stretch_state_t state_q;
    aord_stretch_state_t state_d;
    logic [AORD_CNT_W-1:0] pulse_len;

    // ------------------------------------------------------------
    // pulse length
    // ------------------------------------------------------------
    // 8 * 2**exp cycles; the event cycle counts as the first
    assign pulse_len = AORD_CNT_W'(1) << (AORD_PULSE_BASE_LOG2
                       + int'(flag_if.pulse_length_exp)); // R7

    always_comb begin
        state_d = state_q;
        for (int i = 0; i < AORD_NUM_FLAGS; i++) begin
            if (flag_if.event_hit[i]) begin
                // a new event restarts a running pulse
                state_d.cnt[i] = pulse_len - AORD_CNT_W'(1); // R10
            end else if (state_q.cnt[i] != '0) begin
                state_d.cnt[i] = state_q.cnt[i] - AORD_CNT_W'(1); // R7
            end
            // disabled pins are held low, stretching still runs
            state_d.pin[i] = flag_if.flag_output_enable
                             && (flag_if.event_hit[i]
                                 || state_q.cnt[i] != '0); // R6
        end
    end

    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            state_q <= '0;
        end else begin
            state_q <= state_d;
        end
    end

    assign flag_if.pin_level = state_q.pin;
endmodule // aord_stretch
`default_nettype wire

// ===== tb/aord_top_chk.sv
// checker: port assertions of the overrange detector
`default_nettype none
module aord_top_chk
    import aord_pkg::*;
(
    input wire logic CLK_I,
    input wire logic RESETN_I,
    input wire logic [AORD_SAMPLE_W-1:0] CHAN_A_SAMPLE_I,
    input wire logic [AORD_SAMPLE_W-1:0] CHAN_B_SAMPLE_I,
    input wire logic [9:0] REG_ADDR_I,
    input wire logic [7:0] REG_WDATA_I,
    input wire logic REG_WR_I,
    input wire logic REG_RD_I,
    input wire logic [7:0] REG_RDATA_O,
    input wire logic CHAN_A_PIN_0_O,
    input wire logic CHAN_A_PIN_1_O,
    input wire logic CHAN_B_PIN_0_O,
    input wire logic CHAN_B_PIN_1_O
);
    logic [7:0] t0_q, t1_q, cf_q;
    int c_q;
    function automatic logic [7:0] lvl(input logic [11:0] s);
        logic [11:0] m;
        m = s[11] ? -s : s;
        if (m[11]) m = 12'h7ff;
        return m[10:3];
    endfunction
    wire logic en = cf_q[3];
    always_ff @(posedge CLK_I or negedge RESETN_I) begin
        if (!RESETN_I) begin
            t0_q <= 8'hf2;
            t1_q <= 8'hab;
            cf_q <= 8'h07;
            c_q <= 0;
        end else begin
            c_q <= CHAN_A_PIN_0_O ? c_q + 1 : 0;
            if (REG_WR_I && REG_ADDR_I == 10'h211) t0_q <= REG_WDATA_I;
            if (REG_WR_I && REG_ADDR_I == 10'h212) t1_q <= REG_WDATA_I;
            if (REG_WR_I && REG_ADDR_I == 10'h213) cf_q <= REG_WDATA_I & 8'h0f;
        end
    end
    default clocking @(posedge CLK_I); endclocking
    default disable iff (!RESETN_I);
    sequence s_off; !en ##1 !en; endsequence
    sequence s_rd(a); REG_RD_I && REG_ADDR_I == a; endsequence
    a_thr0_read: assert property (s_rd(10'h211) |=> REG_RDATA_O == t0_q)
        else $error("threshold 0 readback wrong");
    a_thr1_read: assert property (s_rd(10'h212) |=> REG_RDATA_O == t1_q)
        else $error("threshold 1 readback wrong");
    a_cfg_read: assert property (s_rd(10'h213) |=> REG_RDATA_O == cf_q)
        else $error("config readback wrong");
    a_pins_off: assert property (s_off |-> !(CHAN_A_PIN_0_O ||
        CHAN_A_PIN_1_O || CHAN_B_PIN_0_O || CHAN_B_PIN_1_O))
        else $error("pin high while disabled");
    a_a0_hit: assert property (lvl(CHAN_A_SAMPLE_I) >= t0_q && en
        |-> ##[1:3] (CHAN_A_PIN_0_O || !en)) else $error("pin a0 missed");
    a_a1_hit: assert property (lvl(CHAN_A_SAMPLE_I) >= t1_q && en
        |-> ##[1:3] (CHAN_A_PIN_1_O || !en)) else $error("pin a1 missed");
    a_b0_hit: assert property (lvl(CHAN_B_SAMPLE_I) >= t0_q && en
        |-> ##[1:3] (CHAN_B_PIN_0_O || !en)) else $error("pin b0 missed");
    a_b1_hit: assert property (lvl(CHAN_B_SAMPLE_I) >= t1_q && en
        |-> ##[1:3] (CHAN_B_PIN_1_O || !en)) else $error("pin b1 missed");
    a_pulse_width: assert property ($fell(CHAN_A_PIN_0_O) && en
        && $past(en) |-> c_q >= (8 << cf_q[2:0])) else $error("pulse short");
endmodule // aord_top_chk
bind aord_top aord_top_chk i_chk (.CLK_I(CLK_I), .RESETN_I(RESETN_I),
    .CHAN_A_SAMPLE_I(CHAN_A_SAMPLE_I), .CHAN_B_SAMPLE_I(CHAN_B_SAMPLE_I),
    .REG_ADDR_I(REG_ADDR_I), .REG_WDATA_I(REG_WDATA_I), .REG_WR_I(REG_WR_I),
    .REG_RD_I(REG_RD_I), .REG_RDATA_O(REG_RDATA_O),
    .CHAN_A_PIN_0_O(CHAN_A_PIN_0_O), .CHAN_A_PIN_1_O(CHAN_A_PIN_1_O),
    .CHAN_B_PIN_0_O(CHAN_B_PIN_0_O), .CHAN_B_PIN_1_O(CHAN_B_PIN_1_O));
`default_nettype wire

// ===== tb/aord_pin_mon.sv
// model: far-side logic timing each overrange pin pulse
`default_nettype none
module aord_pin_mon (
    input wire logic clk_i,
    input wire logic [3:0] pin_i
);
    timeunit 1ns;
    timeprecision 1ps;
    int cnt[4] = '{default: 0};
    int last_len[4] = '{default: 0};
    int npulse[4] = '{default: 0};
    always @(posedge clk_i) begin
        for (int i = 0; i < 4; i++) begin
            if (pin_i[i]) begin
                cnt[i]++;
            end else if (cnt[i] != 0) begin
                last_len[i] = cnt[i];
                npulse[i]++;
                cnt[i] = 0;
            end
        end
    end
endmodule // aord_pin_mon
`default_nettype wire

// ===== tb/test_adc_overrange_detector.sv
// bench: directed tests of the overrange detector
`default_nettype none
module test_adc_overrange_detector;
    timeunit 1ns;
    timeprecision 1ps;
    `define CHK(n, e, g) begin num_checks++; if ((g) !== (e)) begin \
        errors++; $display("[ERR] %s exp %0h got %0h", n, e, g); end end
    logic clk, rst_n, wr, rd;
    logic [11:0] sa, sb;
    logic [9:0] addr;
    logic [7:0] wd, rdat;
    logic [3:0] pins;
    int errors = 0;
    int num_checks = 0;
    aord_top i_dut (.CLK_I(clk), .RESETN_I(rst_n), .CHAN_A_SAMPLE_I(sa),
        .CHAN_B_SAMPLE_I(sb), .REG_ADDR_I(addr), .REG_WDATA_I(wd),
        .REG_WR_I(wr), .REG_RD_I(rd), .REG_RDATA_O(rdat),
        .CHAN_A_PIN_0_O(pins[0]), .CHAN_A_PIN_1_O(pins[1]),
        .CHAN_B_PIN_0_O(pins[2]), .CHAN_B_PIN_1_O(pins[3]));
    aord_pin_mon i_mon (.clk_i(clk), .pin_i(pins));
    initial begin
        clk = 0;
        forever #2.5 clk = ~clk;
    end
    task automatic wreg(input logic [9:0] a, input logic [7:0] v);
        @(posedge clk);
        wr <= 1;
        addr <= a;
        wd <= v;
        @(posedge clk);
        wr <= 0;
    endtask
    task automatic rreg(input logic [9:0] a, input logic [7:0] e);
        @(posedge clk);
        rd <= 1;
        addr <= a;
        @(posedge clk);
        rd <= 0;
        #1 `CHK("rdata", e, rdat)
    endtask
    // one-cycle samples, exp 0: which pins pulse, and for 8 cycles
    task automatic t_hit(input logic [11:0] a, b, input logic [3:0] m);
        int n[4];
        n = i_mon.npulse;
        @(posedge clk);
        sa <= a;
        sb <= b;
        @(posedge clk);
        sa <= 0;
        sb <= 0;
        repeat (20) @(posedge clk);
        for (int i = 0; i < 4; i++) begin
            `CHK("pulses", int'(m[i]), i_mon.npulse[i] - n[i])
            if (m[i]) `CHK("len", 8, i_mon.last_len[i])
        end
    endtask
    // exp 2: lone event, then a second one 10 cycles later restarts
    task automatic t_len;
        wreg(10'h213, 8'h0a);
        for (int g = 0; g < 11; g += 10) begin
            @(posedge clk);
            sa <= 12'h7ff;
            @(posedge clk);
            sa <= 0;
            if (g > 0) begin
                repeat (g - 1) @(posedge clk);
                sa <= 12'h7ff;
                @(posedge clk);
                sa <= 0;
            end
            repeat (50) @(posedge clk);
            #1 `CHK("len", 32 + g, i_mon.last_len[0])
        end
    endtask
    // reset values, readback, reserved bits and unmapped reads
    task automatic t_regs;
        #1 `CHK("pins", 4'h0, pins)
        rreg(10'h211, 8'hf2);
        rreg(10'h212, 8'hab);
        rreg(10'h213, 8'h07);
        wreg(10'h213, 8'hff);
        rreg(10'h213, 8'h0f);
        rreg(10'h210, 8'h00);
        wreg(10'h211, 8'h80);
        wreg(10'h212, 8'h40);
        wreg(10'h213, 8'h08);
    endtask
    // maximum exponent, as software is advised to keep it
    task automatic t_max;
        wreg(10'h213, 8'h0f);
        @(posedge clk);
        sb <= 12'h800;
        @(posedge clk);
        sb <= 0;
        repeat (1040) @(posedge clk);
        #1 `CHK("len", 1024, i_mon.last_len[3])
    endtask
    // outputs disabled: events leave every pin low
    task automatic t_off;
        wreg(10'h213, 8'h02);
        t_hit(12'h7ff, 12'h7ff, 4'h0);
        wreg(10'h213, 8'h07);
        rreg(10'h213, 8'h07);
    endtask
    task automatic finish_test;
        $display("checks %0d errors %0d", num_checks, errors);
        if (errors == 0 && num_checks > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask
    initial begin
        #20us;
        errors++;
        finish_test;
    end
    initial begin
        {rst_n, wr, rd, addr, wd, sa, sb} = '0;
        repeat (12) @(posedge clk);
        rst_n <= 1;
        repeat (3) @(posedge clk);
        t_regs;
        t_hit(12'h400, 12'h000, 4'h3);
        t_hit(12'h3f8, 12'h000, 4'h2);
        t_hit(12'h000, 12'hc00, 4'hc);
        t_hit(12'h1ff, 12'h800, 4'hc);
        t_len;
        t_max;
        t_off;
        finish_test;
    end
endmodule // test_adc_overrange_detector
`default_nettype wire
